// file: design/guard_switch_pkg.sv
// Constants, states and carrier types of the guard switch supervisor
package guard_switch_pkg;

	// Clock and prescaler
	localparam int CLK_HZ          = 10_000_000;
	localparam int TICK_HZ         = 4;
	localparam int TICK_CYCLES     = CLK_HZ / TICK_HZ;
	localparam int TICK_WIDTH      = 22;

	// Warning duration before forced shutdown
	localparam int WARN_MINUTES    = 30;
	localparam int WARN_TICKS      = WARN_MINUTES * 60 * TICK_HZ;
	localparam int WARN_WIDTH      = 13;

	// Flash sequencer: 16 quarter-second steps per red code frame
	localparam int STEP_WIDTH      = 4;
	localparam int BLINK_BIT       = 1;

	// Red flash counts per error cause
	localparam logic [2:0] CODE_NONE     = 3'h0;
	localparam logic [2:0] CODE_OUT_A    = 3'h1;
	localparam logic [2:0] CODE_OUT_B    = 3'h2;
	localparam logic [2:0] CODE_SHORT    = 3'h3;
	localparam logic [2:0] CODE_TEMP     = 3'h4;
	localparam logic [2:0] CODE_ACTUATOR = 3'h5;

	typedef enum logic [3:0] {
		ST_RUN   = 4'h1,
		ST_WARN  = 4'h2,
		ST_ERROR = 4'h4,
		ST_REARM = 4'h8
	} state_type;

	typedef struct packed {
		logic outA;
		logic outB;
		logic short;
		logic temp;
		logic actuator;
	} fault_type;

	typedef struct packed {
		logic      inA;
		logic      inB;
		logic      present;
		logic      limit;
		fault_type fault;
	} pin_type;

	typedef struct packed {
		logic safeA;
		logic safeB;
		logic aux;
		logic green;
		logic yellow;
		logic red;
	} drive_type;

	localparam pin_type   PIN_RESET   = '0;
	localparam drive_type DRIVE_RESET = '0;

endpackage

// file: design/guard_switch_diagnostic_fsm.sv
// Supervisory state logic of a coded guard-door switch
//
// Summary of operation
// - Warning fault: raise warning, drop auxiliary, delay shutdown.
// - Warning active 30 minutes uncleared disables both safety outputs.
// - Stored error clears only after door opens then closes, fault gone.
// - Green steady only with supply and both upstream inputs present.
// - Green blinks at 1 Hz when either upstream input is missing.
// - Yellow lit whenever a valid actuator is within sensing range.
// - Yellow blinks when actuator sits near the hysteresis band edge.
// - Red lamp active whenever any error condition is present.
// - Door shut, input missing: green blinks, yellow, aux on, outputs off.
// - Auxiliary output reflects the current switching condition.
// - Safety outputs drop at once when actuator leaves sensing zone.
// - Red flash count encodes error cause, one to five pulses.
`timescale 1ns/1ps

module guard_switch_diagnostic_fsm
	import guard_switch_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES,
	parameter int WARN_LEN = WARN_TICKS
)(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic safetyInA,
	input  wire logic safetyInB,
	input  wire logic actuatorPresent,
	input  wire logic actuatorLimit,
	input  wire logic faultOutA,
	input  wire logic faultOutB,
	input  wire logic faultShort,
	input  wire logic faultTemp,
	input  wire logic faultActuator,
	output logic      safetyOutA,
	output logic      safetyOutB,
	output logic      auxOut,
	output logic      ledGreen,
	output logic      ledYellow,
	output logic      ledRed
);

	pin_type                 rawPins;
	pin_type                 syncMeta;
	pin_type                 pins;
	logic [TICK_WIDTH-1:0]   tickCount;
	logic [TICK_WIDTH-1:0]   next_tickCount;
	logic                    tick;
	logic                    next_tick;
	logic [STEP_WIDTH-1:0]   flashStep;
	logic [STEP_WIDTH-1:0]   next_flashStep;
	logic [WARN_WIDTH-1:0]   warnTimer;
	logic [WARN_WIDTH-1:0]   next_warnTimer;
	state_type               state;
	state_type               next_state;
	logic [2:0]              errCode;
	logic [2:0]              next_errCode;
	drive_type               drive;
	drive_type               next_drive;
	logic                    blink;
	logic                    redPattern;
	logic                    warnFault;
	logic                    timeout;
	logic                    inputsOk;

	// Lowest flash count wins when several causes are present
	function automatic logic [2:0] causeCode(input fault_type f);
		if (f.outA)
			return CODE_OUT_A;
		else if (f.outB)
			return CODE_OUT_B;
		else if (f.short)
			return CODE_SHORT;
		else if (f.temp)
			return CODE_TEMP;
		else if (f.actuator)
			return CODE_ACTUATOR;
		return CODE_NONE;
	endfunction

	assign rawPins = '{inA: safetyInA, inB: safetyInB,
		present: actuatorPresent, limit: actuatorLimit,
		fault: '{outA: faultOutA, outB: faultOutB, short: faultShort,
			temp: faultTemp, actuator: faultActuator}};

	// Every pin is asynchronous to clk, so all pass two flops
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			syncMeta <= PIN_RESET;
			pins     <= PIN_RESET;
		end
		else
		begin
			syncMeta <= rawPins;
			pins     <= syncMeta;
		end
	end

	// Quarter-second tick and flash step counter
	always_comb
	begin
		next_tick      = 1'b0;
		next_tickCount = tickCount + 1'b1;
		next_flashStep = flashStep;
		if (tickCount == TICK_WIDTH'(TICK_LEN - 1))
		begin
			next_tickCount = '0;
			next_tick      = 1'b1;
		end
		if (tick)
			next_flashStep = flashStep + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tickCount <= '0;
			tick      <= 1'b0;
			flashStep <= '0;
		end
		else
		begin
			tickCount <= next_tickCount;
			tick      <= next_tick;
			flashStep <= next_flashStep;
		end
	end

	// Four steps per period gives the 1 Hz blink
	assign blink      = flashStep[BLINK_BIT];
	// Pulses on even steps, then a pause closes the frame
	assign redPattern = (flashStep < {errCode, 1'b0}) & ~flashStep[0];
	assign warnFault  = pins.fault.outA | pins.fault.outB |
		pins.fault.short | pins.fault.temp;
	assign timeout    = tick && (warnTimer == WARN_WIDTH'(WARN_LEN - 1));
	assign inputsOk   = pins.inA & pins.inB;

	// Supervisor states, warning timer and registered pin drive
	always_comb
	begin
		next_state     = state;
		next_errCode   = errCode;
		next_warnTimer = '0;
		case (state)
			ST_RUN:
			begin
				if (pins.fault.actuator)
				begin
					next_state   = ST_ERROR;
					next_errCode = CODE_ACTUATOR;
				end
				else if (warnFault)
				begin
					next_state   = ST_WARN;
					next_errCode = causeCode(pins.fault);
				end
			end
			ST_WARN:
			begin
				next_warnTimer = warnTimer + WARN_WIDTH'(tick);
				if (pins.fault.actuator)
				begin
					next_state   = ST_ERROR;
					next_errCode = CODE_ACTUATOR;
				end
				else if (timeout)
					next_state = ST_ERROR;
				else if (!pins.present)
					next_state = warnFault ? ST_ERROR : ST_REARM;
			end
			ST_ERROR:
			begin
				// Opening the door with the cause gone starts the clear
				if (!pins.present && !warnFault && !pins.fault.actuator)
					next_state = ST_REARM;
			end
			ST_REARM:
			begin
				if (warnFault || pins.fault.actuator)
				begin
					next_state   = ST_ERROR;
					next_errCode = causeCode(pins.fault);
				end
				else if (pins.present)
				begin
					next_state   = ST_RUN;
					next_errCode = CODE_NONE;
				end
			end
			default:
			begin
				next_state   = ST_ERROR;
				next_errCode = CODE_NONE;
			end
		endcase

		// Outputs hold only while the actuator is seen this very cycle
		next_drive.safeA = pins.present && inputsOk &&
			(state == ST_RUN || state == ST_WARN);
		next_drive.safeB = next_drive.safeA;
		// Auxiliary tracks actuation, pulsed near the band edge
		next_drive.aux   = (state == ST_RUN) && pins.present &&
			(!pins.limit || blink);
		next_drive.green = (state == ST_RUN || state == ST_REARM) &&
			(inputsOk || blink);
		next_drive.yellow = pins.present && (!pins.limit || blink);
		next_drive.red   = (state == ST_WARN || state == ST_ERROR) &&
			redPattern;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state     <= ST_RUN;
			errCode   <= CODE_NONE;
			warnTimer <= '0;
			drive     <= DRIVE_RESET;
		end
		else
		begin
			state     <= next_state;
			errCode   <= next_errCode;
			warnTimer <= next_warnTimer;
			drive     <= next_drive;
		end
	end

	assign safetyOutA = drive.safeA;
	assign safetyOutB = drive.safeB;
	assign auxOut     = drive.aux;
	assign ledGreen   = drive.green;
	assign ledYellow  = drive.yellow;
	assign ledRed     = drive.red;

	// Door open then closed with no fault pending
	sequence doorOpened_s;
		state == ST_ERROR && !pins.present && !warnFault &&
			!pins.fault.actuator;
	endsequence
	sequence doorClosed_s;
		state == ST_REARM && pins.present && !warnFault &&
			!pins.fault.actuator;
	endsequence

	actuatorGone_a: assert property (@(posedge clk) disable iff (!rst_b)
		!pins.present |=> !safetyOutA && !safetyOutB)
		else $error("safety outputs still high without actuator");
	warnAux_a: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_RUN && warnFault && !pins.fault.actuator
		|=> state == ST_WARN ##1 !auxOut)
		else $error("warning did not drop auxiliary output");
	warnTimeout_a: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_WARN && timeout
		|=> state == ST_ERROR ##1 !safetyOutA && !safetyOutB)
		else $error("warning timeout did not disable outputs");
	doorCycle_a: assert property (@(posedge clk) disable iff (!rst_b)
		doorOpened_s ##1 doorClosed_s |=> state == ST_RUN)
		else $error("door cycle did not clear stored error");
	greenSteady_a: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_RUN && inputsOk |=> ledGreen)
		else $error("green not steady with inputs present");
	greenBlink_a: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_RUN && !inputsOk |=> ledGreen == $past(blink))
		else $error("green not blinking with input missing");
	yellowLamp_a: assert property (@(posedge clk) disable iff (!rst_b)
		pins.present |=> ledYellow == (!$past(pins.limit) || $past(blink)))
		else $error("yellow lamp wrong with actuator present");
	yellowOff_a: assert property (@(posedge clk) disable iff (!rst_b)
		!pins.present |=> !ledYellow)
		else $error("yellow lamp lit without actuator");
	redQuiet_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == ST_RUN || state == ST_REARM) |=> !ledRed)
		else $error("red lamp lit without error");
	inputMissing_a: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_RUN && pins.present && !pins.limit && !inputsOk
		|=> auxOut && !safetyOutA && !safetyOutB)
		else $error("input missing pattern wrong");
	codeActuator_a: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_RUN && pins.fault.actuator |=> errCode == CODE_ACTUATOR)
		else $error("actuator fault not coded as five flashes");
	timerClear_a: assert property (@(posedge clk) disable iff (!rst_b)
		state != ST_WARN |=> warnTimer == '0)
		else $error("warning timer not cleared outside warning");

endmodule

// file: test/guard_switch_partner.sv
// Model of the upstream safety chain and the supervising controller
`timescale 1ns/1ps

module guard_switch_partner(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [1:0] chainClosed,
	input  wire logic       safetyOutA,
	input  wire logic       auxOut,
	output logic            safetyInA,
	output logic            safetyInB,
	output logic            haltRequest
);
	// Upstream doors feed the two channels straight through
	assign safetyInA = chainClosed[1];
	assign safetyInB = chainClosed[0];

	// Controlled stop cue: auxiliary dropped while outputs still enabled
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			haltRequest <= 1'b0;
		else
			haltRequest <= safetyOutA & ~auxOut;
endmodule

// file: test/guard_switch_diagnostic_fsm_tb.sv
// Self-checking bench of the guard switch supervisor
`timescale 1ns/1ps

module guard_switch_diagnostic_fsm_tb
	import guard_switch_pkg::*;
;
	localparam int TL = 4;

	logic       clk;
	logic       rst_b;
	pin_type    pins;
	logic [1:0] chain;
	logic       inA;
	logic       inB;
	logic       halt;
	// Net, since six output ports each drive one member
	wire drive_type drv;
	int         numErrors;
	int         samplesChecked;

	// Short tick and warning spans keep the run brief
	guard_switch_diagnostic_fsm #(.TICK_LEN(TL), .WARN_LEN(3)) i_dut (
		.clk(clk), .rst_b(rst_b), .safetyInA(inA), .safetyInB(inB),
		.actuatorPresent(pins.present), .actuatorLimit(pins.limit),
		.faultOutA(pins.fault.outA), .faultOutB(pins.fault.outB),
		.faultShort(pins.fault.short), .faultTemp(pins.fault.temp),
		.faultActuator(pins.fault.actuator), .safetyOutA(drv.safeA),
		.safetyOutB(drv.safeB), .auxOut(drv.aux), .ledGreen(drv.green),
		.ledYellow(drv.yellow), .ledRed(drv.red));

	guard_switch_partner i_partner (
		.clk(clk), .rst_b(rst_b), .chainClosed(chain),
		.safetyOutA(drv.safeA), .auxOut(drv.aux), .safetyInA(inA),
		.safetyInB(inB), .haltRequest(halt));

	// Free-running clock, 100 ns period
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Inputs always move a fixed 10 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samplesChecked++;
		if (got !== exp)
		begin
			numErrors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic expSafe(input logic p, input logic [1:0] c);
		return p & c[1] & c[0];
	endfunction

	// Counts red pulse starts; one frame window sees each pulse once
	task automatic countRed(output int n);
		logic last;
		n = 0;
		last = drv.red;
		repeat (16 * TL)
		begin
			step(1);
			if (drv.red & ~last)
				n++;
			last = drv.red;
		end
	endtask

	// Looks for both levels of a lamp over two blink periods
	task automatic blinkSeen(input bit yel, output logic both);
		logic [1:0] seen;
		seen = 2'h0;
		repeat (8 * TL)
		begin
			step(1);
			seen[yel ? drv.yellow : drv.green] = 1'b1;
		end
		both = &seen;
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		logic both;
		int   n;
		void'($urandom(87257));
		numErrors = 0;
		samplesChecked = 0;
		rst_b = 1'b0;
		pins = PIN_RESET;
		chain = 2'h3;
		step(10);
		check(8'(drv), 8'(DRIVE_RESET));
		rst_b = 1'b1;
		pins.present = 1'b1;
		step(8);
		check(drv.safeA, expSafe(1'b1, chain));
		check(drv.safeB, 1'b1);
		check(drv.green, 1'b1);
		check(drv.yellow, 1'b1);
		check(drv.aux, 1'b1);
		check(drv.red, 1'b0);
		$display("Test ready state done");
		repeat (4)
		begin
			chain = 2'($urandom_range(0, 2));
			step(6);
			check(drv.safeA, expSafe(1'b1, chain));
			check(drv.aux, 1'b1);
			check(drv.red, 1'b0);
			check(drv.yellow, 1'b1);
			blinkSeen(1'b0, both);
			check(both, 1'b1);
		end
		chain = 2'h3;
		pins.limit = 1'b1;
		step(6);
		check(drv.safeA, 1'b1);
		blinkSeen(1'b1, both);
		check(both, 1'b1);
		pins.limit = 1'b0;
		$display("Test missing input and limit done");
		pins.present = 1'b0;
		step(3);
		check(drv.safeA, 1'b0);
		pins.present = 1'b1;
		step(8);
		$display("Test door open done");
		for (int k = 0; k < 5; k++)
		begin
			pins.fault = fault_type'(5'h10 >> k);
			step(6);
			check(drv.aux, 1'b0);
			check(drv.safeA, k == 4 ? 1'b0 : 1'b1);
			check(halt, k == 4 ? 1'b0 : 1'b1);
			step(40);
			check(drv.safeA, 1'b0);
			countRed(n);
			check(8'(n), 8'(k + 1));
			pins.fault = '0;
			step(10);
			check(drv.safeA, 1'b0);
			pins.present = 1'b0;
			step(10);
			pins.present = 1'b1;
			step(10);
			check(drv.safeA, 1'b1);
			check(drv.red, 1'b0);
		end
		$display("Test fault codes done");
		// Door cycle in warning with the fault gone, before the timeout
		pins.fault = fault_type'(5'h02);
		step(6);
		check(drv.aux, 1'b0);
		pins.fault = '0;
		pins.present = 1'b0;
		step(4);
		check(drv.safeA, 1'b0);
		pins.present = 1'b1;
		step(8);
		check(drv.safeA, 1'b1);
		check(drv.aux, 1'b1);
		// Two causes at once: the lower flash count wins
		pins.fault = fault_type'(5'h0a);
		step(6);
		check(halt, 1'b1);
		countRed(n);
		check(8'(n), 8'h02);
		pins.fault = '0;
		pins.present = 1'b0;
		step(10);
		pins.present = 1'b1;
		step(10);
		check(drv.safeA, 1'b1);
		$display("Test warning clear and priority done");
		conclude();
	end

	// Watchdog, well beyond the expected run length
	initial
	begin
		#400_000;
		numErrors++;
		conclude();
	end
endmodule
